// [rtl/icsp_consts.vh]
// constants for the two-wire command slave port
//
// Contract
// RULE1 - slave only, never drives clock
// RULE2 - host waits 2 ms after supply valid
// RULE3 - nine clock pulses per byte, ack ninth
// RULE4 - data changes only while clock low
// RULE5 - write ends with stop after ack
// RULE6 - read ends with no-ack then stop
// RULE7 - direction fixed per operation, restart changes it
// RULE8 - writes 1-3 bytes, reads 1-2 bytes
// RULE9 - first byte after address loads pointer
// RULE10 - write byte: command then data stored
// RULE11 - read byte: command, restart, read data
// RULE12 - every access sets pointer first
// RULE13 - send, read/write byte, read/write word
// RULE14 - send byte clears latched faults
// RULE15 - word data low byte first
// RULE16 - ack only own address, else release
`ifndef ICSP_CONSTS_VH
`define ICSP_CONSTS_VH

// ==========================================================
// timing
`define ICSP_CLK_MHZ        250
`define ICSP_READY_MS       2
`define ICSP_READY_CYC      (`ICSP_READY_MS * 1000 * `ICSP_CLK_MHZ)

// ==========================================================
// bit and byte layout
`define ICSP_BIT_LAST       4'h7
`define ICSP_BIT_ACK        4'h8
`define ICSP_BYTE_CMD       2'h0
`define ICSP_BYTE_LOW       2'h1
`define ICSP_BYTE_HIGH      2'h2
`define ICSP_BYTE_MAX       2'h3
`define ICSP_DIR_READ       1'h1

`endif

// [rtl/icsp_sync.v]
// two-flop synchroniser with edge finder for the serial pins
`timescale 1ns/10ps
`default_nettype none
module icsp_sync (
   // clock and reset
   input  wire clk_sys,
   input  wire srst,
   // raw pin
   input  wire pinIn,
   // synchronised level and edges
   output reg  level,
   output wire rise,
   output wire fall
);
   reg meta;  // first stage, read only by the second
   reg prev;  // delayed copy for edge detection

   // ==========================================================
   // sample: bus idles high, so reset to high
   always @(posedge clk_sys) begin
      if (srst) begin
         meta  <= 1'b1;
         level <= 1'b1;
         prev  <= 1'b1;
      end else begin
         meta  <= pinIn;
         level <= meta;
         prev  <= level;
      end
   end

   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule // icsp_sync
`default_nettype wire

// [rtl/icsp_slave.v]
// two-wire command slave port: address match, pointer, byte/word transfers
`timescale 1ns/10ps
`include "icsp_consts.vh"
`default_nettype none
module icsp_slave #(
   parameter [6:0]  OWN_ADDR  = 7'h20,           // plain default bus address
   parameter [31:0] READY_CYC = `ICSP_READY_CYC  // supply settle count, shorten in sim
) (
   // clock and reset
   input  wire        clk_sys,
   input  wire        srst,
   // supply status
   input  wire        main5vSupplyOk,
   output reg         portReady,
   // serial pins (clock is input only)
   input  wire        sclIn,
   input  wire        sdaIn,
   output wire        sdaOut,
   output reg         sdaOe,
   // register side
   output reg  [7:0]  cmdPtr,
   output reg         cmdStrobe,
   output reg         writeStrobe,
   output reg  [15:0] writeData,
   output reg  [1:0]  writeCount,
   output reg         readStrobe,
   input  wire [15:0] readData,
   output reg         faultClear
);
   // ==========================================================
   // states
   localparam [2:0] ST_IDLE = 3'h0;  // waiting for start
   localparam [2:0] ST_RX   = 3'h1;  // shifting a byte in
   localparam [2:0] ST_ACK  = 3'h2;  // driving ack
   localparam [2:0] ST_TX   = 3'h3;  // shifting a byte out
   localparam [2:0] ST_MACK = 3'h4;  // sampling master ack
   localparam [2:0] ST_IGN  = 3'h5;  // not ours, refused or done: stay released

   wire       sclL, sclRise, sclFall;
   wire       sdaL, sdaRise, sdaFall;
   reg  [2:0] state;
   reg  [3:0] bitCnt;     // bits seen in current byte
   reg  [7:0] shiftReg;   // receive/transmit shift register
   reg  [1:0] byteIdx;    // bytes after address, command byte included
   reg        isRead;     // direction of this operation
   reg        isAddr;     // next received byte is the address
   reg        cmdSeen;    // pointer set in this transfer
   reg        hiByte;     // reading the high byte
   reg [31:0] readyCnt;   // supply settle counter
   reg        drvLow;     // drive data low

   // pins pass two flops before use
   icsp_sync uScl (.clk_sys(clk_sys), .srst(srst), .pinIn(sclIn),
                   .level(sclL), .rise(sclRise), .fall(sclFall));
   icsp_sync uSda (.clk_sys(clk_sys), .srst(srst), .pinIn(sdaIn),
                   .level(sdaL), .rise(sdaRise), .fall(sdaFall));

   wire startCond = sdaFall & sclL;  // start or repeated start
   wire stopCond  = sdaRise & sclL;  // RULE4

   // open drain: only ever pull low; clock is never driven
   assign sdaOut = 1'b0;  // RULE1

   // ==========================================================
   // supply settle timer, informational for the host side
   always @(posedge clk_sys) begin
      if (srst || !main5vSupplyOk) begin
         readyCnt  <= 32'h0;
         portReady <= 1'b0;
      end else if (readyCnt < READY_CYC) begin
         readyCnt  <= readyCnt + 32'h1;
      end else begin
         portReady <= 1'b1;  // RULE2
      end
   end

   // ==========================================================
   // protocol engine
   always @(posedge clk_sys) begin
      if (srst) begin
         state       <= ST_IDLE;
         bitCnt      <= 4'h0;
         shiftReg    <= 8'h0;
         byteIdx     <= 2'h0;
         isRead      <= 1'b0;
         isAddr      <= 1'b0;
         cmdSeen     <= 1'b0;
         hiByte      <= 1'b0;
         drvLow      <= 1'b0;
         sdaOe       <= 1'b0;
         cmdPtr      <= 8'h00;
         cmdStrobe   <= 1'b0;
         writeStrobe <= 1'b0;
         writeData   <= 16'h0000;
         writeCount  <= 2'h0;
         readStrobe  <= 1'b0;
         faultClear  <= 1'b0;
      end else begin
         cmdStrobe   <= 1'b0;
         writeStrobe <= 1'b0;
         readStrobe  <= 1'b0;
         faultClear  <= 1'b0;
         sdaOe       <= drvLow;
         if (startCond) begin
            // repeated start keeps pointer, new address decides direction
            state   <= ST_RX;  // RULE7
            bitCnt  <= 4'h0;
            isAddr  <= 1'b1;
            drvLow  <= 1'b0;
            sdaOe   <= 1'b0;
            hiByte  <= 1'b0;
         end else if (stopCond) begin
            // end of write: commit what arrived
            if (state != ST_IGN && !isRead && cmdSeen) begin
               if (byteIdx == `ICSP_BYTE_LOW) begin
                  faultClear <= 1'b1;  // RULE14
               end else begin
                  writeStrobe <= 1'b1;  // RULE10 RULE13
                  writeCount  <= byteIdx - 2'h1;  // RULE8
               end
            end
            state   <= ST_IDLE;
            cmdSeen <= 1'b0;
            byteIdx <= 2'h0;
            drvLow  <= 1'b0;
            sdaOe   <= 1'b0;
         end else begin
            case (state)
               ST_RX: begin
                  if (sclRise) begin
                     shiftReg <= {shiftReg[6:0], sdaL};
                     bitCnt   <= bitCnt + 4'h1;
                  end else if (sclFall && bitCnt == `ICSP_BIT_ACK) begin  // RULE3
                     bitCnt <= 4'h0;
                     if (isAddr) begin
                        isAddr <= 1'b0;
                        if (shiftReg[7:1] == OWN_ADDR) begin  // RULE16
                           isRead <= shiftReg[0] == `ICSP_DIR_READ;
                           drvLow <= 1'b1;
                           state  <= ST_ACK;
                           if (shiftReg[0] != `ICSP_DIR_READ) begin
                              byteIdx <= `ICSP_BYTE_CMD;
                              cmdSeen <= 1'b0;  // RULE12
                           end
                        end else begin
                           state <= ST_IGN;
                        end
                     end else if (byteIdx == `ICSP_BYTE_CMD) begin
                        cmdPtr    <= shiftReg;  // RULE9
                        cmdStrobe <= 1'b1;
                        cmdSeen   <= 1'b1;
                        byteIdx   <= `ICSP_BYTE_LOW;
                        drvLow    <= 1'b1;
                        state     <= ST_ACK;
                     end else if (byteIdx != `ICSP_BYTE_MAX) begin
                        // low byte first, then high
                        if (byteIdx == `ICSP_BYTE_LOW)
                           writeData[7:0]  <= shiftReg;  // RULE15
                        else
                           writeData[15:8] <= shiftReg;
                        byteIdx <= byteIdx + 2'h1;
                        drvLow  <= 1'b1;
                        state   <= ST_ACK;
                     end else begin
                        // longer than three bytes: refuse with no ack
                        state <= ST_IGN;
                     end
                  end
               end
               ST_ACK: begin
                  // hold ack through the ninth pulse, release on its fall
                  if (sclFall) begin
                     if (isRead && cmdSeen) begin
                        shiftReg   <= hiByte ? readData[15:8] : readData[7:0];  // RULE11
                        readStrobe <= ~hiByte;
                        drvLow     <= hiByte ? ~readData[15] : ~readData[7];
                        bitCnt     <= 4'h0;
                        state      <= ST_TX;
                     end else if (isRead) begin
                        drvLow <= 1'b0;  // no pointer set: send nothing
                        state  <= ST_IGN;
                     end else begin
                        drvLow <= 1'b0;
                        state  <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  // shift on falling clock so data is steady while high
                  if (sclFall) begin  // RULE4
                     if (bitCnt == `ICSP_BIT_LAST) begin
                        drvLow <= 1'b0;
                        state  <= ST_MACK;
                     end else begin
                        shiftReg <= {shiftReg[6:0], 1'b0};
                        drvLow   <= ~shiftReg[6];
                     end
                     bitCnt <= bitCnt + 4'h1;
                  end
               end
               ST_MACK: begin
                  if (sclRise) begin
                     if (sdaL || hiByte) begin
                        state <= ST_IGN;  // RULE6
                     end else begin
                        hiByte <= 1'b1;  // second byte of word
                        state  <= ST_ACK;
                     end
                  end
               end
               ST_IGN: begin
                  drvLow <= 1'b0;
               end
               default: begin
                  state  <= ST_IDLE;
                  drvLow <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule // icsp_slave
`default_nettype wire

// [verification/icsp_slave_assertions.sv]
// assertion checker for the command slave port
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// checker
module icsp_slave_assertions #(
   parameter [31:0] READY_CYC = 32'h32  // settle count, handed on by bind
) (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       srst,
   // supply and pins
   input wire logic       main5vSupplyOk,
   input wire logic       portReady,
   input wire logic       sclIn,
   input wire logic       sdaIn,
   input wire logic       sdaOut,
   input wire logic       sdaOe,
   // register side
   input wire logic       writeStrobe,
   input wire logic       faultClear,
   input wire logic [1:0] writeCount
);
   logic [31:0] supCnt;  // cycles with supply good
   // counts from supply good, restarts on any drop
   always_ff @(posedge clk_sys) begin
      supCnt <= (srst || !main5vSupplyOk) ? 32'h0 : supCnt + 32'h1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_stop; sclIn && sdaIn; endsequence  // lines idle after stop
   sequence s_held; sdaOe [*8]; endsequence      // drive lasts past the bit edge
   a_open_drain: assert property (sdaOe |-> !sdaOut) else $error("data driven high");
   a_ready_wait: assert property ($rose(portReady) |-> supCnt >= READY_CYC - 1)
      else $error("port ready too early");
   a_drive_clk_low: assert property ($rose(sdaOe) |-> !sclIn)
      else $error("data drive began with clock high");
   a_drive_held: assert property ($rose(sdaOe) |-> s_held)
      else $error("data drive too short");
   a_write_at_stop: assert property (writeStrobe |-> s_stop ##1 !writeStrobe)
      else $error("write strobe away from stop");
   a_clear_at_stop: assert property (faultClear |-> s_stop ##1 !faultClear)
      else $error("fault clear away from stop");
   a_write_count: assert property (writeStrobe |-> writeCount <= 2'h2)
      else $error("write length beyond three bytes");
   a_strobe_excl: assert property (!(writeStrobe && faultClear))
      else $error("write and clear together");
   a_reset_quiet: assert property ($fell(srst) |-> !sdaOe && !portReady)
      else $error("outputs busy after reset");
endmodule // icsp_slave_assertions
`default_nettype wire

// [verification/icsp_host_model.sv]
// host master model driving the serial pins
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// host master
module icsp_host_model (
   // pins
   output var logic scl,     // serial clock, host side only
   output var logic sdaLow,  // host pulls data low
   input wire logic sda      // resolved data level
);
   // idle: clock stands high between frames, data released
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   // one bit out, data moved only while clock low
   task automatic bitOut(input logic b);
      sdaLow = !b;
      #20 scl = 1'b1;
      #40 scl = 1'b0;
      #20;
   endtask
   // one bit in, data released by host
   task automatic bitIn(output logic b);
      sdaLow = 1'b0;
      #20 scl = 1'b1;
      #20 b = sda;
      #20 scl = 1'b0;
      #20;
   endtask
   // start or repeated start, direction set anew
   task automatic start;
      sdaLow = 1'b0;
      #20 scl = 1'b1;
      #20 sdaLow = 1'b1;
      #20 scl = 1'b0;
      #20;
   endtask
   // data low before the clock, high during it
   task automatic stop;
      sdaLow = 1'b1;
      #20 scl = 1'b1;
      #20 sdaLow = 1'b0;
      #40;
   endtask
   // eight bits then the slave acknowledge
   task automatic wrByte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bitOut(d[i]);
      bitIn(b);
      ack = !b;
   endtask
   // eight bits in, then host ack or no-ack
   task automatic rdByte(output logic [7:0] d, input logic more);
      for (int i = 7; i >= 0; i--) bitIn(d[i]);
      bitOut(!more);
   endtask
endmodule // icsp_host_model
`default_nettype wire

// [verification/icsp_slave_tb.sv]
// self-checking bench for the command slave port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", nm, e, s); end end
// ==========================================================
// bench top
module icsp_slave_tb;
   logic        clk_sys = 1'b0;  // 250 MHz
   logic        srst = 1'b1;     // sync reset
   logic        supOk = 1'b0;    // supply good
   logic        portReady, sdaOut, sdaOe, cmdStrobe, writeStrobe, readStrobe, faultClear;
   logic [7:0]  cmdPtr;
   logic [15:0] writeData;
   logic [1:0]  writeCount;
   wire logic   scl, hostLow;
   wire logic   sda = !((sdaOe && !sdaOut) || hostLow);  // pull-up on data
   int err_total = 0, n_compared = 0, nWr = 0, nClr = 0, nRd = 0, nCmd = 0;
   always #2 clk_sys = !clk_sys;
   // count one-cycle strobes
   always @(posedge clk_sys) begin
      nWr += (writeStrobe === 1'b1);
      nClr += (faultClear === 1'b1);
      nRd += (readStrobe === 1'b1);
      nCmd += (cmdStrobe === 1'b1);
   end
   icsp_slave #(.OWN_ADDR(7'h20), .READY_CYC(32'h32)) u_icsp_slave (.clk_sys(clk_sys),
      .srst(srst), .main5vSupplyOk(supOk), .portReady(portReady), .sclIn(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .cmdPtr(cmdPtr), .cmdStrobe(cmdStrobe),
      .writeStrobe(writeStrobe), .writeData(writeData), .writeCount(writeCount),
      .readStrobe(readStrobe), .readData(16'hB47E), .faultClear(faultClear));
   icsp_host_model u_icsp_host_model (.scl(scl), .sdaLow(hostLow), .sda(sda));
   // verdict and end of run
   task automatic complete_run;
      $display("mismatches %0d compares %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // let strobes land, step off the edge
   task automatic settle;
      repeat (20) @(posedge clk_sys);
      #1;
   endtask
   // write with n data bytes, n = 0 is send byte
   task automatic wrXfer(input int n);
      logic a;
      int w0 = nWr, c0 = nClr, m0 = nCmd;
      u_icsp_host_model.start();
      u_icsp_host_model.wrByte(8'h40, a);
      `CHK("addr ack", 1'b1, a)
      u_icsp_host_model.wrByte(8'h3C + n[7:0], a);
      `CHK("cmd ack", 1'b1, a)
      for (int k = 0; k < n; k++) begin
         u_icsp_host_model.wrByte(8'h10 + k[7:0], a);
         `CHK("data ack", k < 2, a)
      end
      u_icsp_host_model.stop();
      settle();
      `CHK("pointer", 8'h3C + n[7:0], cmdPtr)
      `CHK("fault clear", n == 0, nClr - c0)
      `CHK("cmd strobe", 1, nCmd - m0)
      `CHK("write strobe", n == 1 || n == 2, nWr - w0)
      if (n == 1 || n == 2) begin
         `CHK("write count", n[1:0], writeCount)
         `CHK("low data", 8'h10, writeData[7:0])
         if (n > 1) `CHK("high data", 8'h11, writeData[15:8])
      end
   endtask
   // read word, with or without command byte first
   task automatic rdWord(input logic withCmd);
      logic a;
      logic [7:0] lo, hi;
      int r0 = nRd;
      u_icsp_host_model.start();
      if (withCmd) begin
         u_icsp_host_model.wrByte(8'h40, a);
         u_icsp_host_model.wrByte(8'h5A, a);
         u_icsp_host_model.start();
      end
      u_icsp_host_model.wrByte(8'h41, a);
      `CHK("read addr ack", 1'b1, a)
      u_icsp_host_model.rdByte(lo, 1'b1);
      u_icsp_host_model.rdByte(hi, 1'b0);
      u_icsp_host_model.stop();
      settle();
      if (withCmd) begin
         `CHK("low byte", 8'h7E, lo)
         `CHK("high byte", 8'hB4, hi)
         `CHK("read strobe", 1, nRd - r0)
      end
      else begin
         `CHK("no command data", 8'hFF, lo)
         `CHK("no read strobe", 0, nRd - r0)
      end
   endtask
   // foreign address: no ack, nothing stored
   task automatic otherAddr;
      logic a;
      int w0 = nWr;
      u_icsp_host_model.start();
      u_icsp_host_model.wrByte(8'h42, a);
      `CHK("foreign ack", 1'b0, a)
      u_icsp_host_model.wrByte(8'h3C, a);
      `CHK("foreign cmd ack", 1'b0, a)
      u_icsp_host_model.stop();
      settle();
      `CHK("foreign write", 0, nWr - w0)
   endtask
   // main sequence
   initial begin
      int k;
      repeat (8) @(posedge clk_sys);
      #1 srst = 1'b0;
      supOk = 1'b1;
      for (k = 0; k < 200 && portReady !== 1'b1; k++) begin
         @(posedge clk_sys);
         #1;
      end
      `CHK("ready wait", 1'b1, k >= 49 && k < 200)
      if (k == 200) complete_run();
      for (int n = 0; n < 5; n++) wrXfer(n);
      rdWord(1'b1);
      rdWord(1'b0);
      otherAddr();
      complete_run();
   end
   // hang guard
   initial begin
      #200000;
      err_total++;
      complete_run();
   end
endmodule // icsp_slave_tb
bind icsp_slave icsp_slave_assertions #(.READY_CYC(READY_CYC)) u_icsp_slave_assertions (
   .clk_sys(clk_sys), .srst(srst), .main5vSupplyOk(main5vSupplyOk), .portReady(portReady),
   .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeStrobe(writeStrobe),
   .faultClear(faultClear), .writeCount(writeCount));
`default_nettype wire
